// ---- pkg/mbio_defines.svh ----
// Offsets, field positions, reset values and the serial pin number of the byte port.
`ifndef MBIO_DEFINES_SVH
`define MBIO_DEFINES_SVH
`define MBIO_OFS_PIN_LEVEL 12'h000
`define MBIO_OFS_OUT_LATCH 12'h004
`define MBIO_OFS_PIN_DIR 12'h008
`define MBIO_OFS_MEM_CTRL 12'h00C
`define MBIO_OFS_PSP_CTRL 12'h010
`define MBIO_OFS_SER_CTRL 12'h014
`define MBIO_BIT_EXT_BUS_DIS 7
`define MBIO_BIT_PSP_EN 4
`define MBIO_BIT_SER_EN 0
`define MBIO_SER_PIN 4
`define MBIO_RST_DIR 8'hFF
`define MBIO_RST_LATCH 8'h00
`define MBIO_RST_MEM_CTRL 8'h00
`define MBIO_RST_PSP_CTRL 8'h00
`define MBIO_RST_SER_CTRL 8'h00
`endif

// ---- pkg/mbio_pkg.sv ----
// Types shared by the byte port modules.
package mbio_pkg;
  typedef logic [7:0] mbio_byte_t;
  typedef enum logic [1:0] {
    MBIO_PH_IDLE = 2'b01,
    MBIO_PH_DATA = 2'b10
  } mbio_phase_t;
endpackage

// ---- pkg/mbio_sync_if.sv ----
// Raw and synchronised pin levels passed between port modules.
`timescale 1ns/1ps
`default_nettype none
interface mbio_sync_if;
  logic [7:0] raw;
  logic [7:0] synced;
  modport src (output raw, input synced);
  modport syn (input raw, output synced);
endinterface
`default_nettype wire

// ---- verilog/mbio_sync.sv ----
// Two-flip-flop synchroniser for the eight pin levels.
`timescale 1ns/1ps
`default_nettype none
module mbio_sync (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Pin levels
  mbio_sync_if.syn s
);
  logic [7:0] meta_reg;
  logic [7:0] sync_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
    end else begin
      meta_reg <= s.raw;
      sync_reg <= meta_reg;
    end
  end
  assign s.synced = sync_reg;
endmodule
`default_nettype wire

// ---- verilog/mbio_port.sv ----
// Shared byte port: AHB-Lite registers and pin multiplexer.
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mbio_defines.svh"
module mbio_port (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // External memory interface, low byte
  input wire logic ext_ad_drive_i,
  input wire mbio_pkg::mbio_byte_t ext_ad_out_i,
  output mbio_pkg::mbio_byte_t ext_data_in_o,
  // Parallel slave port host strobes, already in this clock domain
  input wire logic psp_host_rd_i,
  input wire logic psp_host_wr_i,
  output mbio_pkg::mbio_byte_t psp_wr_data_o,
  output logic psp_wr_stb_o,
  // Second serial unit data output
  input wire logic ser_data_out_i,
  // Pins
  input wire mbio_pkg::mbio_byte_t pin_i,
  output mbio_pkg::mbio_byte_t pin_o,
  output mbio_pkg::mbio_byte_t pin_oe_o
);
  import mbio_pkg::*;

  mbio_sync_if sif ();
  assign sif.raw = pin_i;
  mbio_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .s(sif.syn)
  );

  mbio_phase_t ph_reg, ph_next;
  logic [11:0] addr_reg, addr_next;
  logic wr_reg, wr_next;
  mbio_byte_t latch_reg, latch_next;
  mbio_byte_t dir_reg, dir_next;
  logic [7:0] mem_ctrl_reg, mem_ctrl_next;
  logic [7:0] psp_ctrl_reg, psp_ctrl_next;
  logic [7:0] ser_ctrl_reg, ser_ctrl_next;
  logic [31:0] rdata_reg, rdata_next;
  mbio_byte_t pin_reg, pin_next;
  mbio_byte_t oe_reg, oe_next;
  mbio_byte_t ext_in_reg, ext_in_next;
  mbio_byte_t psp_data_reg, psp_data_next;
  logic psp_stb_reg, psp_stb_next;
  logic ready_reg, ready_next;
  logic resp_reg, resp_next;
  logic ext_en, psp_en, ser_en, take;

  // Bus writes land in the data phase, so a read issued right after a write still returns the old value.
  assign take = hsel_i & hready_i & htrans_i[1];
  assign ext_en = ~mem_ctrl_reg[`MBIO_BIT_EXT_BUS_DIS];
  assign psp_en = psp_ctrl_reg[`MBIO_BIT_PSP_EN];
  assign ser_en = ser_ctrl_reg[`MBIO_BIT_SER_EN];

  always_comb begin
    ph_next = ph_reg;
    addr_next = addr_reg;
    wr_next = wr_reg;
    latch_next = latch_reg;
    dir_next = dir_reg;
    mem_ctrl_next = mem_ctrl_reg;
    psp_ctrl_next = psp_ctrl_reg;
    ser_ctrl_next = ser_ctrl_reg;
    rdata_next = rdata_reg;
    ready_next = 1'b1;
    resp_next = 1'b0;
    if (ph_reg == MBIO_PH_DATA && wr_reg) begin
      case (addr_reg)
        `MBIO_OFS_PIN_LEVEL: latch_next = hwdata_i[7:0];
        `MBIO_OFS_OUT_LATCH: latch_next = hwdata_i[7:0];
        `MBIO_OFS_PIN_DIR: dir_next = hwdata_i[7:0];
        `MBIO_OFS_MEM_CTRL: mem_ctrl_next = hwdata_i[7:0];
        `MBIO_OFS_PSP_CTRL: psp_ctrl_next = hwdata_i[7:0];
        `MBIO_OFS_SER_CTRL: ser_ctrl_next = hwdata_i[7:0];
        default: begin
        end
      endcase
    end
    if (take) begin
      ph_next = MBIO_PH_DATA;
      addr_next = {haddr_i[11:2], 2'b00};
      wr_next = hwrite_i;
      case ({haddr_i[11:2], 2'b00})
        `MBIO_OFS_PIN_LEVEL: rdata_next = {24'h000000, sif.synced};
        `MBIO_OFS_OUT_LATCH: rdata_next = {24'h000000, latch_reg};
        `MBIO_OFS_PIN_DIR: rdata_next = {24'h000000, dir_reg};
        `MBIO_OFS_MEM_CTRL: rdata_next = {24'h000000, mem_ctrl_reg};
        `MBIO_OFS_PSP_CTRL: rdata_next = {24'h000000, psp_ctrl_reg};
        `MBIO_OFS_SER_CTRL: rdata_next = {24'h000000, ser_ctrl_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end else if (hready_i) begin
      ph_next = MBIO_PH_IDLE;
    end
  end

  // Pin multiplexer; priority is bus, serial on pin four, slave port, port.
  always_comb begin
    pin_next = latch_reg;
    oe_next = ~dir_reg;
    if (psp_en) begin
      pin_next = latch_reg;
      oe_next = {8{psp_host_rd_i}};
    end
    if (ser_en && !dir_reg[`MBIO_SER_PIN]) begin
      pin_next[`MBIO_SER_PIN] = ser_data_out_i;
      oe_next[`MBIO_SER_PIN] = 1'b1;
    end
    if (ext_en) begin
      pin_next = ext_ad_out_i;
      oe_next = {8{ext_ad_drive_i}};
    end
    ext_in_next = ext_en ? sif.synced : ext_in_reg;
    psp_stb_next = psp_en & ~ext_en & psp_host_wr_i;
    psp_data_next = psp_stb_next ? sif.synced : psp_data_reg;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_reg <= MBIO_PH_IDLE;
      addr_reg <= 12'h000;
      wr_reg <= 1'b0;
      latch_reg <= `MBIO_RST_LATCH;
      dir_reg <= `MBIO_RST_DIR;
      mem_ctrl_reg <= `MBIO_RST_MEM_CTRL;
      psp_ctrl_reg <= `MBIO_RST_PSP_CTRL;
      ser_ctrl_reg <= `MBIO_RST_SER_CTRL;
      rdata_reg <= 32'h00000000;
      ready_reg <= 1'b1;
      resp_reg <= 1'b0;
      pin_reg <= 8'h00;
      oe_reg <= 8'h00;
      ext_in_reg <= 8'h00;
      psp_data_reg <= 8'h00;
      psp_stb_reg <= 1'b0;
    end else begin
      ph_reg <= ph_next;
      addr_reg <= addr_next;
      wr_reg <= wr_next;
      latch_reg <= latch_next;
      dir_reg <= dir_next;
      mem_ctrl_reg <= mem_ctrl_next;
      psp_ctrl_reg <= psp_ctrl_next;
      ser_ctrl_reg <= ser_ctrl_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      resp_reg <= resp_next;
      pin_reg <= pin_next;
      oe_reg <= oe_next;
      ext_in_reg <= ext_in_next;
      psp_data_reg <= psp_data_next;
      psp_stb_reg <= psp_stb_next;
    end
  end

  // Zero wait states, so the ready output can be a constant flip-flop.
  assign hrdata_o = rdata_reg;
  assign hreadyout_o = ready_reg;
  assign hresp_o = resp_reg;
  assign pin_o = pin_reg;
  assign pin_oe_o = oe_reg;
  assign ext_data_in_o = ext_in_reg;
  assign psp_wr_data_o = psp_data_reg;
  assign psp_wr_stb_o = psp_stb_reg;

  property p_dir_in;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (!ext_en && !psp_en && !ser_en) |=> (oe_reg == ~$past(dir_reg));
  endproperty
  a_dir_in: assert property (p_dir_in)
    else $error("oe not from dir");

  property p_latch_out;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (!ext_en && !psp_en && !ser_en) |=> (pin_reg == $past(latch_reg));
  endproperty
  a_latch_out: assert property (p_latch_out)
    else $error("pin not latch");

  property p_reset_in;
    @(posedge ref_clk_i) $rose(rst_n_i) |-> (dir_reg == 8'hFF);
  endproperty
  a_reset_in: assert property (p_reset_in)
    else $error("dir not input");

  property p_ext_wins;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ext_en |=> (pin_reg == $past(ext_ad_out_i)) &&
               (oe_reg == {8{$past(ext_ad_drive_i)}});
  endproperty
  a_ext_wins: assert property (p_ext_wins)
    else $error("bus lost");

  property p_psp_rd;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (psp_en && !ext_en && !ser_en && psp_host_rd_i) |=>
      (oe_reg == 8'hFF) && (pin_reg == $past(latch_reg));
  endproperty
  a_psp_rd: assert property (p_psp_rd)
    else $error("psp read");

  property p_ser_pin;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (!ext_en && ser_en && !dir_reg[4]) |=>
      oe_reg[4] && (pin_reg[4] == $past(ser_data_out_i));
  endproperty
  a_ser_pin: assert property (p_ser_pin)
    else $error("serial pin");

  property p_ext_in;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ext_en |=> ext_in_reg == $past(sif.synced);
  endproperty
  a_ext_in: assert property (p_ext_in)
    else $error("bus data in");

  property p_latch_rb;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (take && !hwrite_i && haddr_i[11:2] == 10'h001) |=>
      rdata_reg[7:0] == $past(latch_reg);
  endproperty
  a_latch_rb: assert property (p_latch_rb)
    else $error("latch read");

  property p_psp_wr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (psp_en && !ext_en && psp_host_wr_i) |=> psp_stb_reg;
  endproperty
  a_psp_wr: assert property (p_psp_wr)
    else $error("psp write");

  property p_psp_idle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (psp_en && !ext_en && !ser_en && !psp_host_rd_i) |=> (oe_reg == 8'h00);
  endproperty
  a_psp_idle: assert property (p_psp_idle)
    else $error("psp drives");

  property p_psp_data;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (psp_en && !ext_en && psp_host_wr_i) |=>
      (psp_data_reg == $past(sif.synced));
  endproperty
  a_psp_data: assert property (p_psp_data)
    else $error("psp data");

  property p_no_stb;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (ext_en || !psp_en || !psp_host_wr_i) |=> !psp_stb_reg;
  endproperty
  a_no_stb: assert property (p_no_stb)
    else $error("stray strobe");

  property p_dir_wr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (ph_reg == MBIO_PH_DATA && wr_reg && addr_reg == `MBIO_OFS_PIN_DIR) |=>
      (dir_reg == $past(hwdata_i[7:0]));
  endproperty
  a_dir_wr: assert property (p_dir_wr)
    else $error("dir write");

  property p_pin_wr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (ph_reg == MBIO_PH_DATA && wr_reg && addr_reg == `MBIO_OFS_PIN_LEVEL) |=>
      (latch_reg == $past(hwdata_i[7:0]));
  endproperty
  a_pin_wr: assert property (p_pin_wr)
    else $error("level write");

  property p_lvl_rd;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (take && !hwrite_i && haddr_i[11:2] == 10'h000) |=>
      rdata_reg[7:0] == $past(sif.synced);
  endproperty
  a_lvl_rd: assert property (p_lvl_rd)
    else $error("level read");

  c_ext: cover property (@(posedge ref_clk_i) ext_en && ext_ad_drive_i);
  c_psp: cover property (@(posedge ref_clk_i) psp_stb_reg);
  c_ser: cover property (@(posedge ref_clk_i) ser_en && !ext_en);
  c_psp_rd: cover property (@(posedge ref_clk_i) psp_en && psp_host_rd_i);
  c_wr: cover property (@(posedge ref_clk_i) ph_reg == MBIO_PH_DATA && wr_reg);
endmodule
`default_nettype wire

// ---- dv/mbio_pin_model.sv ----
// Behavioural model of the pins and of the host driving them.
`timescale 1ns/1ps
`default_nettype none
module mbio_pin_model (
  // Clock
  input wire logic ref_clk_i,
  // Device side
  input wire logic [7:0] pin_o_i,
  input wire logic [7:0] pin_oe_i,
  // Host side
  input wire logic [7:0] host_en_i,
  input wire logic [7:0] host_val_i,
  output logic [7:0] level_o
);
  logic [7:0] float_reg = 8'h55;
  // Undriven pins change every cycle, so a stale level never passes.
  always_ff @(posedge ref_clk_i) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_i[i]) level_o[i] = pin_o_i[i];
      else if (host_en_i[i]) level_o[i] = host_val_i[i];
      else level_o[i] = float_reg[i];
    end
  end
endmodule
`default_nettype wire

// ---- dv/mbio_port_tb.sv ----
// Self-checking bench for the shared byte port.
`timescale 1ns/1ps
`default_nettype none
`include "mbio_defines.svh"
module mbio_port_tb;
  import mbio_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hwrite = 1'h0, ext_drv = 1'h0, rd_stb = 1'h0, wr_stb = 1'h0;
  logic ser = 1'h0;
  logic hready, hresp, psp_stb;
  mbio_byte_t ext_out = 8'h00, ext_in, wr_data, pin_in, pin_out, pin_oe;
  logic [7:0] host_en = 8'h00, host_val = 8'h00;
  int n_errors = 0;
  int comparisons = 0;
  mbio_port u_mbio_port (
    .ref_clk_i(clk), .rst_n_i(rst_n), .hsel_i(1'h1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .ext_ad_drive_i(ext_drv), .ext_ad_out_i(ext_out),
    .ext_data_in_o(ext_in), .psp_host_rd_i(rd_stb), .psp_host_wr_i(wr_stb),
    .psp_wr_data_o(wr_data), .psp_wr_stb_o(psp_stb),
    .ser_data_out_i(ser), .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe));
  mbio_pin_model u_mbio_pin_model (.ref_clk_i(clk), .pin_o_i(pin_out),
    .pin_oe_i(pin_oe), .host_en_i(host_en), .host_val_i(host_val),
    .level_o(pin_in));
  task automatic finish_test();
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    if (hready !== 1'h1) begin
      n_errors++;
      finish_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    edge_ready();
    htrans <= 2'h0;
    hwdata <= d;
    edge_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_reset();
    xfer(1'h0, `MBIO_OFS_PIN_DIR, 32'h0);
    chk(rd, `MBIO_RST_DIR);
    xfer(1'h0, `MBIO_OFS_OUT_LATCH, 32'h0);
    chk(rd, `MBIO_RST_LATCH);
    host_en <= 8'hFF;
    host_val <= 8'h3C;
    settle();
    chk({pin_oe, ext_in}, 16'h003C);
    @(posedge clk);
    ext_drv <= 1'h1;
    ext_out <= 8'hA5;
    settle();
    chk({pin_oe, pin_out}, 16'hFFA5);
    @(posedge clk);
    ext_drv <= 1'h0;
  endtask
  task automatic t_port();
    wr(`MBIO_OFS_OUT_LATCH, 32'h5A);
    wr(`MBIO_OFS_PIN_DIR, 32'h0F);
    host_en <= 8'h0F;
    host_val <= 8'h0C;
    settle();
    chk(pin_oe, 8'h00);
    wr(`MBIO_OFS_MEM_CTRL, 32'h80);
    settle();
    chk({pin_oe, pin_out & pin_oe}, 16'hF050);
    xfer(1'h0, `MBIO_OFS_PIN_LEVEL, 32'h0);
    chk(rd, 32'h5C);
    chk(hresp, 1'h0);
    wr(`MBIO_OFS_PIN_LEVEL, 32'h33);
    xfer(1'h0, `MBIO_OFS_OUT_LATCH, 32'h0);
    chk(rd, 32'h33);
    xfer(1'h0, 12'h020, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_serial();
    wr(`MBIO_OFS_SER_CTRL, 32'h1);
    wr(`MBIO_OFS_PIN_DIR, 32'hEF);
    wr(`MBIO_OFS_OUT_LATCH, 32'h0);
    ser <= 1'h1;
    host_en <= 8'h00;
    settle();
    chk({pin_oe, pin_out}, 16'h1010);
    wr(`MBIO_OFS_MEM_CTRL, 32'h0);
    ext_drv <= 1'h1;
    ext_out <= 8'h6B;
    settle();
    chk({pin_oe, pin_out}, 16'hFF6B);
  endtask
  task automatic t_psp();
    int n;
    wr(`MBIO_OFS_SER_CTRL, 32'h0);
    wr(`MBIO_OFS_MEM_CTRL, 32'h80);
    wr(`MBIO_OFS_PSP_CTRL, 32'h10);
    wr(`MBIO_OFS_OUT_LATCH, 32'h96);
    wr(`MBIO_OFS_PIN_DIR, 32'h0);
    ext_drv <= 1'h0;
    rd_stb <= 1'h1;
    settle();
    chk({pin_oe, pin_out}, 16'hFF96);
    @(posedge clk);
    rd_stb <= 1'h0;
    host_en <= 8'hFF;
    host_val <= 8'hC3;
    settle();
    chk(pin_oe, 8'h00);
    @(posedge clk);
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
    for (n = 0; n < 10 && psp_stb !== 1'h1; n++) @(negedge clk);
    if (psp_stb !== 1'h1) begin
      n_errors++;
      finish_test();
    end
    chk(wr_data, 8'hC3);
    wr(`MBIO_OFS_MEM_CTRL, 32'h0);
    ext_drv <= 1'h1;
    ext_out <= 8'h21;
    rd_stb <= 1'h1;
    settle();
    chk({pin_oe, pin_out}, 16'hFF21);
  endtask
  task automatic t_rereset();
    @(posedge clk);
    rst_n <= 1'h0;
    ext_drv <= 1'h0;
    rd_stb <= 1'h0;
    @(negedge clk);
    chk({pin_oe, pin_out}, 16'h0000);
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    xfer(1'h0, `MBIO_OFS_PIN_DIR, 32'h0);
    chk(rd, `MBIO_RST_DIR);
    xfer(1'h0, `MBIO_OFS_OUT_LATCH, 32'h0);
    chk(rd, `MBIO_RST_LATCH);
  endtask
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_port();
    t_serial();
    t_psp();
    t_rereset();
    finish_test();
  end
endmodule
`default_nettype wire
